// ### iptu_pkg.sv
// Shared constants for the interrupt priority and trap unit.
// Assumes one clock domain; every file that needs a number imports this package.
package iptu_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_SRC = 8;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int VEC_W = 24;
   localparam int NUM_W = 8;
   localparam int LVL_W = 4;
   localparam int TRAP_EVT_W = 10;
   localparam int TFR_W = 8;

   // ------------------------------------------------------------
   // Source control register layout
   // ------------------------------------------------------------
   localparam int CTL_W = 8;
   localparam int GRP_LSB = 0;
   localparam int RANK_LSB = 2;
   localparam int RANK_MSB = 5;
   localparam int GATE_BIT = 6;
   localparam int PEND_BIT = 7;
   localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
   localparam logic [7:0] RSV_ZERO = 8'h00;

   // ------------------------------------------------------------
   // Register map, word indices
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTL_BASE = 5'h00;
   localparam logic [ADDR_W-1:0] TFR_ADDR = 5'h10;
   localparam logic [ADDR_W-1:0] MASK_ADDR = 5'h11;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 5'h12;

   // ------------------------------------------------------------
   // Trap event inputs and trap flag bits
   // ------------------------------------------------------------
   localparam int EVT_SW_RESET = 0;
   localparam int EVT_WDT_OVF = 1;
   localparam int EVT_FIRST_FLAG = 2;
   localparam int TF_NMI = 0;
   localparam int TF_STACK_OVER = 1;
   localparam int TF_STACK_UNDER = 2;
   localparam int TF_CLASS_B_LSB = 3;
   localparam int TF_CLASS_B_MSB = 7;

   // ------------------------------------------------------------
   // Vectors, trap numbers and levels
   // ------------------------------------------------------------
   localparam logic [VEC_W-1:0] RESET_VEC = 24'h000000;
   localparam logic [VEC_W-1:0] NONMASKABLE_VECTOR = 24'h000008;
   localparam logic [VEC_W-1:0] STACK_OVER_VECTOR = 24'h000010;
   localparam logic [VEC_W-1:0] STACK_UNDER_VECTOR = 24'h000018;
   localparam logic [VEC_W-1:0] CLASS_B_VECTOR = 24'h000028;
   localparam logic [NUM_W-1:0] RESET_NUM = 8'h00;
   localparam logic [NUM_W-1:0] NMI_NUM = 8'h02;
   localparam logic [NUM_W-1:0] STACK_OVER_NUM = 8'h04;
   localparam logic [NUM_W-1:0] STACK_UNDER_NUM = 8'h06;
   localparam logic [NUM_W-1:0] CLASS_B_NUM = 8'h0a;
   localparam logic [VEC_W-1:0] INT_VEC_BASE = 24'h000040;
   localparam logic [NUM_W-1:0] INT_NUM_BASE = 8'h10;
   localparam logic [LVL_W-1:0] LVL_MAX = 4'hf;

   // Trap service state, one-hot.
   typedef enum logic [3:0] {
      SVC_NONE = 4'b0001,
      SVC_B = 4'b0010,
      SVC_A = 4'b0100,
      SVC_RST = 4'b1000
   } iptu_svc_t;
endpackage

// ### iptu_src_ctl.sv
// One source control register with its request-pending flag.
// Assumes the parent decodes word and bit writes; all inputs synchronous.
`timescale 1ns/1ps
`default_nettype none
module iptu_src_ctl
   import iptu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic word_wr,
   input wire logic [CTL_W-1:0] wdata,
   input wire logic bit_wr,
   input wire logic [2:0] bit_idx,
   input wire logic bit_val,
   input wire logic hw_set,
   input wire logic ack_clr,
   output logic [CTL_W-1:0] ctl_q
);
   logic [CTL_W-1:0] ctl_d;

   // ------------------------------------------------------------
   // Register update
   // ------------------------------------------------------------
   // Software word and bit writes land first, then the hardware request
   // is ORed in last so a request arriving with any clear is never lost.
   always_comb begin
      ctl_d = ctl_q;
      if (word_wr) begin
         ctl_d = wdata;
      end else if (bit_wr) begin
         ctl_d[bit_idx] = bit_val;
      end
      if (ack_clr) begin
         ctl_d[PEND_BIT] = 1'b0;
      end
      if (hw_set) begin
         ctl_d[PEND_BIT] = 1'b1;
      end
   end

   // Only the low byte exists; the reserved byte has no storage at all.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_q <= CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end
endmodule
`default_nettype wire

// ### iptu_core.sv
// Interrupt priority and trap unit: per-source control, arbitration,
// trap ladder, trap flag register with interrupt output.
// Assumes the CPU acknowledges a presented vector with a one-cycle pulse
// and reports the end of trap service with a one-cycle pulse.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Control state lives in low byte only
// - Reserved high byte reads zero, ignores writes
// - All bits readable, writable, bit addressable
// - Group level breaks equal-rank ties, 3 highest
// - Four-bit rank, Fh highest, 0h lowest
// - Gate bit clear excludes request from arbitration
// - Pending flag set when source requests
// - Resets vector 0, number 0, top rank
// - Class A traps have own vectors
// - Class B traps share vector 28h, 0Ah
// - Trap service forces CPU level 15
// - Traps preempt; interrupts blocked during trap; the code unblocks them once a preempting trap returns
// - Each trap except the two resets sets its trap flag bit
module iptu_core
   import iptu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic bit_wr,
   input wire logic [3:0] bit_idx,
   input wire logic bit_val,
   input wire logic [NUM_SRC-1:0] src_req,
   input wire logic [TRAP_EVT_W-1:0] trap_evt,
   input wire logic [LVL_W-1:0] cpu_level,
   input wire logic cpu_ack,
   input wire logic trap_done,
   output logic [DATA_W-1:0] rdata_q,
   output logic req_vld_q,
   output logic req_is_trap_q,
   output logic [VEC_W-1:0] vec_q,
   output logic [NUM_W-1:0] num_q,
   output logic [LVL_W-1:0] new_level_q,
   output logic irq_q
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [CTL_W-1:0] ctl [NUM_SRC];
   logic [NUM_SRC-1:0] ack_src;
   logic [TFR_W-1:0] tfr_q;
   logic [TFR_W-1:0] mask_q;
   logic rst_pend_q;
   logic [2:0] a_pend_q;
   logic b_pend_q;
   iptu_svc_t svc_q;
   logic [2:0] src_q;
   logic take_ack;
   logic int_found;
   logic [2:0] int_idx;
   logic [5:0] int_key;
   logic cand_vld;
   logic cand_trap;
   logic [VEC_W-1:0] cand_vec;
   logic [NUM_W-1:0] cand_num;
   logic [LVL_W-1:0] cand_lvl;

   // Word address of a source control register, if any.
   function automatic logic is_ctl(input logic [ADDR_W-1:0] a);
      return (a >= CTL_BASE) && (a < CTL_BASE + ADDR_W'(NUM_SRC));
   endfunction

   assign take_ack = cpu_ack && req_vld_q;

   // ------------------------------------------------------------
   // Source control registers
   // ------------------------------------------------------------
   // A bit write to index 8..15 falls into the reserved byte and is dropped.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
         logic sel;
         assign sel = is_ctl(addr) && (addr[2:0] == 3'(gi));
         assign ack_src[gi] = take_ack && !req_is_trap_q && (src_q == 3'(gi));
         iptu_src_ctl u_ctl (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .word_wr(wr_stb && sel),
            .wdata(wdata[CTL_W-1:0]),
            .bit_wr(bit_wr && sel && !bit_idx[3]),
            .bit_idx(bit_idx[2:0]),
            .bit_val(bit_val),
            .hw_set(src_req[gi]),
            .ack_clr(ack_src[gi]),
            .ctl_q(ctl[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Interrupt arbitration
   // ------------------------------------------------------------
   // Key is rank over group, so one compare orders both fields; equal
   // keys keep the lower index, which makes the result deterministic.
   always_comb begin
      int_found = 1'b0;
      int_idx = 3'h0;
      int_key = 6'h00;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (ctl[i][PEND_BIT] && ctl[i][GATE_BIT]
               && (ctl[i][RANK_MSB:RANK_LSB] > cpu_level)
               && (!int_found || ctl[i][RANK_MSB:GRP_LSB] > int_key)) begin
            int_found = 1'b1;
            int_idx = 3'(i);
            int_key = ctl[i][RANK_MSB:GRP_LSB];
         end
      end
   end

   // ------------------------------------------------------------
   // Trap ladder and candidate selection
   // ------------------------------------------------------------
   // A trap is offered only when it outranks the one in service;
   // interrupts are offered only with no trap in service.
   always_comb begin
      cand_vld = 1'b0;
      cand_trap = 1'b0;
      cand_vec = RESET_VEC;
      cand_num = RESET_NUM;
      cand_lvl = LVL_MAX;
      if (rst_pend_q && svc_q != SVC_RST) begin
         cand_vld = 1'b1;
         cand_trap = 1'b1;
      end else if (a_pend_q != 3'b000 && (svc_q == SVC_NONE || svc_q == SVC_B)) begin
         cand_vld = 1'b1;
         cand_trap = 1'b1;
         if (a_pend_q[TF_NMI]) begin
            cand_vec = NONMASKABLE_VECTOR;
            cand_num = NMI_NUM;
         end else if (a_pend_q[TF_STACK_OVER]) begin
            cand_vec = STACK_OVER_VECTOR;
            cand_num = STACK_OVER_NUM;
         end else begin
            cand_vec = STACK_UNDER_VECTOR;
            cand_num = STACK_UNDER_NUM;
         end
      end else if (b_pend_q && svc_q == SVC_NONE) begin
         cand_vld = 1'b1;
         cand_trap = 1'b1;
         cand_vec = CLASS_B_VECTOR;
         cand_num = CLASS_B_NUM;
      end else if (int_found && svc_q == SVC_NONE) begin
         cand_vld = 1'b1;
         cand_vec = INT_VEC_BASE + {19'h00000, int_idx, 2'b00};
         cand_num = INT_NUM_BASE + {5'h00, int_idx};
         cand_lvl = ctl[int_idx][RANK_MSB:RANK_LSB];
      end
   end

   // ------------------------------------------------------------
   // Trap requests waiting for service
   // ------------------------------------------------------------
   // New events are ORed in after the acknowledge clear, so a trap that
   // repeats during its own acknowledge is served again.
   // Clears decode the offered number; the candidate may have moved on.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pend_q <= 1'b0;
         a_pend_q <= 3'b000;
         b_pend_q <= 1'b0;
      end else begin
         rst_pend_q <= (rst_pend_q && !(take_ack && svc_q != SVC_RST && req_is_trap_q
                        && num_q == RESET_NUM))
                       || trap_evt[EVT_SW_RESET] || trap_evt[EVT_WDT_OVF];
         a_pend_q <= (a_pend_q & ~({3{take_ack && req_is_trap_q}}
                     & {num_q == STACK_UNDER_NUM, num_q == STACK_OVER_NUM, num_q == NMI_NUM}))
                     | trap_evt[EVT_FIRST_FLAG +: 3];
         b_pend_q <= (b_pend_q && !(take_ack && req_is_trap_q && num_q == CLASS_B_NUM))
                     || (|trap_evt[TRAP_EVT_W-1:EVT_FIRST_FLAG+3]);
      end
   end

   // Service state; a return always drops back to no trap in service,
   // so a preempted lower trap does not regain its blocking rank.
   // The class entered is that of the acknowledged offer.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         svc_q <= SVC_NONE;
      end else if (take_ack && req_is_trap_q) begin
         svc_q <= (num_q == RESET_NUM) ? SVC_RST
                  : (num_q == CLASS_B_NUM) ? SVC_B : SVC_A;
      end else if (trap_done) begin
         svc_q <= SVC_NONE;
      end
   end

   // ------------------------------------------------------------
   // Request presented to the CPU
   // ------------------------------------------------------------
   // The offer drops for one cycle after an acknowledge so the cleared
   // flag is seen before the next arbitration result is offered.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_vld_q <= 1'b0;
         req_is_trap_q <= 1'b0;
         vec_q <= RESET_VEC;
         num_q <= RESET_NUM;
         new_level_q <= LVL_MAX;
         src_q <= 3'h0;
      end else if (take_ack) begin
         req_vld_q <= 1'b0;
      end else begin
         req_vld_q <= cand_vld;
         req_is_trap_q <= cand_trap;
         vec_q <= cand_vec;
         num_q <= cand_num;
         new_level_q <= cand_lvl;
         src_q <= int_idx;
      end
   end

   // ------------------------------------------------------------
   // Trap flags, mask and interrupt output
   // ------------------------------------------------------------
   // Write one to clear; a trap in the same cycle keeps its flag set.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tfr_q <= '0;
      end else begin
         tfr_q <= (tfr_q & ~((wr_stb && addr == TFR_ADDR) ? wdata[TFR_W-1:0] : '0))
                  | trap_evt[TRAP_EVT_W-1:EVT_FIRST_FLAG];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_q <= '0;
      end else if (wr_stb && addr == MASK_ADDR) begin
         mask_q <= wdata[TFR_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(tfr_q & mask_q);
      end
   end

   // ------------------------------------------------------------
   // Register read
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= '0;
      end else if (rd_stb) begin
         if (is_ctl(addr)) begin
            rdata_q <= {RSV_ZERO, ctl[addr[2:0]]};
         end else if (addr == TFR_ADDR) begin
            rdata_q <= {RSV_ZERO, tfr_q};
         end else if (addr == MASK_ADDR) begin
            rdata_q <= {RSV_ZERO, mask_q};
         end else if (addr == STAT_ADDR) begin
            rdata_q <= {11'h000, svc_q, req_vld_q};
         end else begin
            rdata_q <= '0;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_rsv_zero;
      @(posedge ref_clk) disable iff (!arst_n)
      (rd_stb && is_ctl(addr)) |=> (rdata_q[15:8] == 8'h00);
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved byte not zero");

   property p_rst_vec;
      @(posedge ref_clk) disable iff (!arst_n)
      (req_vld_q && req_is_trap_q && num_q == RESET_NUM) |-> (vec_q == RESET_VEC);
   endproperty
   a_rst_vec: assert property (p_rst_vec) else $error("reset vector wrong");

   property p_a_vec;
      @(posedge ref_clk) disable iff (!arst_n)
      (req_vld_q && num_q == STACK_OVER_NUM) |-> (vec_q == STACK_OVER_VECTOR);
   endproperty
   a_a_vec: assert property (p_a_vec) else $error("class A vector wrong");

   property p_b_vec;
      @(posedge ref_clk) disable iff (!arst_n)
      (req_vld_q && req_is_trap_q && num_q == CLASS_B_NUM) |-> (vec_q == CLASS_B_VECTOR);
   endproperty
   a_b_vec: assert property (p_b_vec) else $error("class B vector wrong");

   property p_trap_level;
      @(posedge ref_clk) disable iff (!arst_n)
      (req_vld_q && req_is_trap_q) |-> (new_level_q == LVL_MAX);
   endproperty
   a_trap_level: assert property (p_trap_level) else $error("trap level not max");

   property p_no_int_in_trap;
      @(posedge ref_clk) disable iff (!arst_n)
      (svc_q != SVC_NONE) |=> !(req_vld_q && !req_is_trap_q);
   endproperty
   a_no_int_in_trap: assert property (p_no_int_in_trap) else $error("interrupt in trap");

   property p_tfr_set;
      @(posedge ref_clk) disable iff (!arst_n)
      (|trap_evt[TRAP_EVT_W-1:EVT_FIRST_FLAG]) |=>
         ((tfr_q & $past(trap_evt[TRAP_EVT_W-1:EVT_FIRST_FLAG]))
          == $past(trap_evt[TRAP_EVT_W-1:EVT_FIRST_FLAG]));
   endproperty
   a_tfr_set: assert property (p_tfr_set) else $error("trap flag not set");

   property p_int_above;
      @(posedge ref_clk) disable iff (!arst_n)
      (req_vld_q && !req_is_trap_q && !$past(take_ack)) |-> (new_level_q > $past(cpu_level));
   endproperty
   a_int_above: assert property (p_int_above) else $error("interrupt not above cpu level");

   property p_ack_clr;
      @(posedge ref_clk) disable iff (!arst_n)
      (take_ack && !req_is_trap_q && !src_req[src_q]) |=> !ctl[$past(src_q)][PEND_BIT];
   endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("pending not cleared");

   c_int_taken: cover property (@(posedge ref_clk) disable iff (!arst_n)
      take_ack && !req_is_trap_q);
   c_trap_taken: cover property (@(posedge ref_clk) disable iff (!arst_n)
      take_ack && req_is_trap_q);
   c_preempt: cover property (@(posedge ref_clk) disable iff (!arst_n)
      svc_q == SVC_B && take_ack && req_is_trap_q && num_q != CLASS_B_NUM);
endmodule
`default_nettype wire

// ### iptu_cpu_model.sv
// CPU core stand-in for the interrupt priority and trap unit: it accepts
// offered requests and ends trap service after a programmable delay.
// Assumes the unit's offer outputs are registered on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module iptu_cpu_model
   import iptu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic ack_en,
   input wire logic [7:0] ack_wait,
   input wire logic [7:0] done_wait,
   input wire logic req_vld_q,
   input wire logic req_is_trap_q,
   input wire logic [VEC_W-1:0] vec_q,
   input wire logic [NUM_W-1:0] num_q,
   input wire logic [LVL_W-1:0] new_level_q,
   output logic cpu_ack,
   output logic trap_done,
   output logic [VEC_W-1:0] got_vec,
   output logic [NUM_W-1:0] got_num,
   output logic [LVL_W-1:0] got_lvl,
   output logic got_trap,
   output logic [15:0] ack_cnt
);
   logic [7:0] wait_q;
   logic [7:0] done_q;
   logic busy_q;

   // Acknowledge after the offer has stood ack_wait+1 cycles; the offer is taken
   // as it stands on the ack edge, since a better request may replace it.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_ack <= 1'b0;
         wait_q <= 8'h00;
         got_vec <= '0;
         got_num <= '0;
         got_lvl <= '0;
         got_trap <= 1'b0;
         ack_cnt <= 16'h0000;
      end else if (cpu_ack) begin
         cpu_ack <= 1'b0;
         wait_q <= 8'h00;
         if (req_vld_q) begin
            got_vec <= vec_q;
            got_num <= num_q;
            got_lvl <= new_level_q;
            got_trap <= req_is_trap_q;
            ack_cnt <= ack_cnt + 16'h0001;
         end
      end else if (req_vld_q && ack_en && wait_q >= ack_wait) begin
         cpu_ack <= 1'b1;
      end else if (req_vld_q) begin
         wait_q <= wait_q + 8'h01;
      end else begin
         wait_q <= 8'h00;
      end
   end

   // Trap service lasts done_wait+1 cycles; a preempting trap restarts it.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         trap_done <= 1'b0;
         done_q <= 8'h00;
         busy_q <= 1'b0;
      end else begin
         trap_done <= 1'b0;
         if (cpu_ack && req_vld_q && req_is_trap_q) begin
            busy_q <= 1'b1;
            done_q <= 8'h00;
         end else if (busy_q && done_q == done_wait) begin
            trap_done <= 1'b1;
            busy_q <= 1'b0;
         end else if (busy_q) begin
            done_q <= done_q + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ### test_iptu_core.sv
// Self-checking testbench for the interrupt priority and trap unit.
// Assumes the CPU stand-in model answers offers; registers via strobes.
`timescale 1ns/1ps
`default_nettype none
module test_iptu_core;
   import iptu_pkg::*;
   logic ref_clk, arst_n, wr_stb, rd_stb, bit_wr, bit_val, cpu_ack, trap_done;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata_q, d;
   logic [3:0] bit_idx;
   logic [NUM_SRC-1:0] src_req;
   logic [TRAP_EVT_W-1:0] trap_evt;
   logic [LVL_W-1:0] cpu_level, new_level_q, got_lvl;
   logic req_vld_q, req_is_trap_q, irq_q, ack_en, got_trap;
   logic [VEC_W-1:0] vec_q, got_vec;
   logic [NUM_W-1:0] num_q, got_num;
   logic [7:0] ack_wait, done_wait;
   logic [15:0] ack_cnt, n0;
   int failures = 0;
   int cmp_count = 0;
   logic [VEC_W-1:0] tvec [10] = '{RESET_VEC, RESET_VEC, NONMASKABLE_VECTOR, STACK_OVER_VECTOR,
      STACK_UNDER_VECTOR, CLASS_B_VECTOR, CLASS_B_VECTOR, CLASS_B_VECTOR, CLASS_B_VECTOR,
      CLASS_B_VECTOR};
   logic [NUM_W-1:0] tnum [10] = '{RESET_NUM, RESET_NUM, NMI_NUM, STACK_OVER_NUM,
      STACK_UNDER_NUM, CLASS_B_NUM, CLASS_B_NUM, CLASS_B_NUM, CLASS_B_NUM, CLASS_B_NUM};

   iptu_core dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .bit_wr(bit_wr), .bit_idx(bit_idx),
      .bit_val(bit_val), .src_req(src_req), .trap_evt(trap_evt), .cpu_level(cpu_level),
      .cpu_ack(cpu_ack), .trap_done(trap_done), .rdata_q(rdata_q), .req_vld_q(req_vld_q),
      .req_is_trap_q(req_is_trap_q), .vec_q(vec_q), .num_q(num_q),
      .new_level_q(new_level_q), .irq_q(irq_q));
   iptu_cpu_model cpu_u (.ref_clk(ref_clk), .arst_n(arst_n), .ack_en(ack_en),
      .ack_wait(ack_wait), .done_wait(done_wait), .req_vld_q(req_vld_q),
      .req_is_trap_q(req_is_trap_q), .vec_q(vec_q), .num_q(num_q),
      .new_level_q(new_level_q), .cpu_ack(cpu_ack), .trap_done(trap_done),
      .got_vec(got_vec), .got_num(got_num), .got_lvl(got_lvl), .got_trap(got_trap),
      .ack_cnt(ack_cnt));

   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge ref_clk) {addr, wdata, wr_stb} <= {a, v, 1'b1};
      @(posedge ref_clk) wr_stb <= 1'b0;
   endtask

   // Read data load on the edge after the strobe and hold until the next strobe; sample just after that edge.
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge ref_clk) {addr, rd_stb} <= {a, 1'b1};
      @(posedge ref_clk) rd_stb <= 1'b0;
      #1 v = rdata_q;
   endtask

   task automatic bw(input logic [4:0] a, input logic [3:0] i, input logic v);
      @(posedge ref_clk) {addr, bit_idx, bit_val, bit_wr} <= {a, i, v, 1'b1};
      @(posedge ref_clk) bit_wr <= 1'b0;
   endtask

   // Bounded wait for the model to count one more acceptance.
   task automatic wait_ack(input logic [15:0] c0, input int lim);
      int k;
      k = 0;
      while (ack_cnt === c0 && k < lim) begin
         @(posedge ref_clk);
         k++;
      end
      #1 chk({23'h0, ack_cnt !== c0}, 24'h1);
   endtask

   task automatic pulse_trap(input logic [9:0] ev);
      @(posedge ref_clk) trap_evt <= ev;
      @(posedge ref_clk) trap_evt <= 10'h000;
   endtask

   // Two sources request together; win[3] set means nothing may be taken.
   task automatic arb(input logic [2:0] ia, input logic [7:0] ca, input logic [2:0] ib,
         input logic [7:0] cb, input logic [3:0] lvl, input logic [3:0] win);
      logic [7:0] wc;
      logic [15:0] v;
      wc = (win[2:0] == ia) ? ca : cb;
      wr({2'b00, ia}, {8'h00, ca});
      wr({2'b00, ib}, {8'h00, cb});
      @(posedge ref_clk) src_req <= (8'h01 << ia) | (8'h01 << ib);
      @(posedge ref_clk) src_req <= 8'h00;
      rd({2'b00, ia}, v);
      chk(v, {8'h00, ca | 8'h80});
      n0 = ack_cnt;
      cpu_level <= lvl;
      ack_en <= 1'b1;
      if (win[3]) begin
         repeat (20) @(posedge ref_clk);
         chk(ack_cnt, n0);
      end else begin
         wait_ack(n0, 50);
         chk(got_vec, INT_VEC_BASE + {19'h0, win[2:0], 2'b00});
         chk(got_num, INT_NUM_BASE + {5'h0, win[2:0]});
         chk(got_lvl, wc[5:2]);
         rd({2'b00, win[2:0]}, v);
         chk(v, {8'h00, wc});
      end
      ack_en <= 1'b0;
      cpu_level <= 4'hf;
      wr({2'b00, ia}, 16'h0000);
      wr({2'b00, ib}, 16'h0000);
   endtask

   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // The run needs under a thousand cycles; twenty thousand means a hang.
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      final_report;
   end

   initial begin
      {arst_n, wr_stb, rd_stb, bit_wr, bit_val, ack_en} = 6'h00;
      {addr, wdata, bit_idx, src_req, trap_evt} = '0;
      cpu_level = 4'hf;
      ack_wait = 8'h03;
      done_wait = 8'h02;
      repeat (12) @(posedge ref_clk);
      chk(new_level_q, LVL_MAX);
      chk({req_vld_q, irq_q}, 24'h0);
      arst_n <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         rd(a[4:0], d);
         chk(d, {8'h00, CTL_RESET});
      end
      rd(TFR_ADDR, d);
      chk(d, 24'h0);
      rd(MASK_ADDR, d);
      chk(d, 24'h0);
      wr(STAT_ADDR, 16'hffff);
      rd(STAT_ADDR, d);
      chk(d, 24'h0002);
      wr(5'h1f, 16'h00ff);
      rd(5'h1f, d);
      chk(d, 24'h0);
      // Word and bit access to one control register.
      wr(5'h03, 16'habcd);
      rd(5'h03, d);
      chk(d, 24'h00cd);
      bw(5'h03, 4'h0, 1'b0);
      bw(5'h03, 4'h7, 1'b0);
      bw(5'h03, 4'h9, 1'b1);
      bw(5'h03, 4'h5, 1'b1);
      rd(5'h03, d);
      chk(d, 24'h006c);
      wr(5'h03, 16'h0000);
      // Arbitration cases.
      arb(3'd1, 8'h54, 3'd2, 8'h57, 4'h0, 4'h2);
      arb(3'd4, 8'h67, 3'd6, 8'h7c, 4'h0, 4'h6);
      arb(3'd0, 8'h3c, 3'd5, 8'h48, 4'h0, 4'h5);
      arb(3'd3, 8'h5c, 3'd0, 8'h3c, 4'h7, 4'h8);
      arb(3'd3, 8'h60, 3'd7, 8'h5f, 4'h7, 4'h3);
      // Every trap event, one at a time.
      ack_en <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         n0 = ack_cnt;
         pulse_trap(10'h001 << i);
         wait_ack(n0, 50);
         chk(got_vec, tvec[i]);
         chk(got_num, tnum[i]);
         chk({got_trap, got_lvl}, {19'h0, 1'b1, LVL_MAX});
         rd(TFR_ADDR, d);
         chk(d, (i < 2) ? 24'h0 : 24'h1 << (i - 2));
         wr(TFR_ADDR, 16'h00ff);
         repeat (8) @(posedge ref_clk);
      end
      // Simultaneous traps are served in ladder order.
      ack_en <= 1'b0;
      pulse_trap(10'h034);
      repeat (4) @(posedge ref_clk);
      ack_en <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         n0 = ack_cnt;
         wait_ack(n0, 50);
         chk(got_num, (i == 0) ? NMI_NUM : (i == 1) ? STACK_UNDER_NUM : CLASS_B_NUM);
      end
      repeat (8) @(posedge ref_clk);
      // A long class B service blocks interrupts, yet an NMI preempts it.
      done_wait <= 8'hff;
      n0 = ack_cnt;
      pulse_trap(10'h040);
      wait_ack(n0, 50);
      rd(STAT_ADDR, d);
      chk(d, 24'h0004);
      wr(5'h07, 16'h00fc);
      cpu_level <= 4'h0;
      n0 = ack_cnt;
      repeat (10) @(posedge ref_clk);
      chk(ack_cnt, n0);
      pulse_trap(10'h004);
      wait_ack(n0, 50);
      chk(got_num, NMI_NUM);
      n0 = ack_cnt;
      wait_ack(n0, 400);
      chk({got_trap, got_num}, {15'h0, 1'b0, INT_NUM_BASE + 8'h07});
      cpu_level <= 4'hf;
      done_wait <= 8'h02;
      wr(TFR_ADDR, 16'h00ff);
      // Trap flags raise the interrupt output only through the mask.
      wr(MASK_ADDR, 16'hff02);
      rd(MASK_ADDR, d);
      chk(d, 24'h0002);
      pulse_trap(10'h008);
      repeat (3) @(posedge ref_clk);
      #1 chk(irq_q, 24'h1);
      wr(MASK_ADDR, 16'h0000);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq_q, 24'h0);
      wr(MASK_ADDR, 16'h0002);
      wr(TFR_ADDR, 16'h0002);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq_q, 24'h0);
      rd(TFR_ADDR, d);
      chk(d, 24'h0);
      repeat (10) @(posedge ref_clk);
      final_report;
   end
endmodule
`default_nettype wire
